//--- verilog/adc_chip_integration_control.sv
// Purpose: Chip-level control around a 10-bit SAR converter: input routing,
//          conversion clock choice and division, trigger choice, register access.
// Assumes: Avalon-MM slave with one wait cycle; power mode from the system controller.
// Notes: Clock sources from pins are sampled and turned into tick enables.
//
// The implementer's own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps

// Functional notes
// - Decode channel codes onto pins, ground, references.
// - Reserved codes still convert; result undefined.
// - Code 11111 disables converter, nothing routed.
// - Code 10110 routes temperature sensor.
// - Code 10111 routes bandgap reference.
// - Ten-bit successive-approximation conversion.
// - Four clock sources: bus, bus/2, async, alternate.
// - Alternate clock comes from external oscillator.
// - Alternate clock keeps running in wait mode.
// - Alternate clock unusable in deep stop.
// - Hardware trigger from counter overflow or timer.
// - Counter overflow trigger still works in deep stop.
// - Timer 0 channels 0,1 and timer 1 channel 0.
module adc_chip_integration_control #(
  parameter int RES_WIDTH = adc_ctl_pkg::RES_BITS
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata_ff,
  output logic waitrequest_ff,
  input wire logic [1:0] power_mode,
  input wire logic ext_osc_output,
  input wire logic local_async_conv_clock,
  input wire logic rtc_overflow,
  input wire logic tmr0_ch0_out,
  input wire logic tmr0_ch1_out,
  input wire logic tmr1_ch0_out,
  input wire logic cmp_high,
  output logic [2:0] ext_pin_sel_ff,
  output logic ext_pin_en_ff,
  output logic vss_sel_ff,
  output logic temp_sel_ff,
  output logic bandgap_sel_ff,
  output logic vrefh_sel_ff,
  output logic vrefl_sel_ff,
  output logic conv_enable_ff,
  output logic [RES_WIDTH-1:0] dac_code_ff,
  output logic sample_on_ff
);

  localparam int NSYNC = 6;

  logic [adc_ctl_pkg::CTRL_BITS-1:0] ctrl_ff;
  logic [adc_ctl_pkg::CTRL_BITS-1:0] nxt_ctrl;
  logic done_flag_ff;
  logic sw_start_ff;
  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;
  logic [NSYNC-1:0] sync3_ff;
  logic [NSYNC-1:0] rise;
  logic bus_half_ff;
  logic [2:0] div_cnt_ff;
  logic src_tick;
  logic conv_tick;
  logic hw_trig;
  logic start_req;
  logic deep_stop;
  logic acc_wr;
  logic acc_rd;
  logic busy;
  logic done_pulse;
  logic [RES_WIDTH-1:0] result;
  logic [4:0] channel_select_field;
  logic [1:0] clock_divide_field;
  adc_ctl_pkg::clk_src_t clk_sel;
  adc_ctl_pkg::trig_src_t trig_sel;

  assign channel_select_field = ctrl_ff[adc_ctl_pkg::CTRL_CH_HI:adc_ctl_pkg::CTRL_CH_LO];
  assign clock_divide_field = ctrl_ff[adc_ctl_pkg::CTRL_DIV_HI:adc_ctl_pkg::CTRL_DIV_LO];
  assign clk_sel = adc_ctl_pkg::clk_src_t'(ctrl_ff[adc_ctl_pkg::CTRL_CLK_HI:
    adc_ctl_pkg::CTRL_CLK_LO]);
  assign trig_sel = adc_ctl_pkg::trig_src_t'(ctrl_ff[adc_ctl_pkg::CTRL_TRIG_HI:
    adc_ctl_pkg::CTRL_TRIG_LO]);
  assign deep_stop = (power_mode == adc_ctl_pkg::PWR_DEEP_STOP);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin inputs: two flip-flops each, then a third stage for rising-edge detection.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
    end
    else
    begin
      sync1_ff <= {cmp_high, tmr1_ch0_out, tmr0_ch1_out, tmr0_ch0_out, rtc_overflow,
        ext_osc_output};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_edge
      assign rise[gi] = sync2_ff[gi] & ~sync3_ff[gi];
    end
  endgenerate

  // The local asynchronous clock has its own synchroniser pair.
  logic async_s1_ff;
  logic async_s2_ff;
  logic async_s3_ff;
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      async_s1_ff <= 1'b0;
      async_s2_ff <= 1'b0;
      async_s3_ff <= 1'b0;
    end
    else
    begin
      async_s1_ff <= local_async_conv_clock;
      async_s2_ff <= async_s1_ff;
      async_s3_ff <= async_s2_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Conversion clock: source selection and division by 1, 2, 4 or 8.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      bus_half_ff <= 1'b0;
    end
    else
    begin
      bus_half_ff <= ~bus_half_ff;
    end
  end

  always_comb
  begin
    case (clk_sel)
      adc_ctl_pkg::CLK_BUS: src_tick = 1'b1;
      adc_ctl_pkg::CLK_BUS_DIV2: src_tick = bus_half_ff;
      adc_ctl_pkg::CLK_ALT: src_tick = rise[0] & ~deep_stop;
      adc_ctl_pkg::CLK_ASYNC: src_tick = async_s2_ff & ~async_s3_ff;
      default: src_tick = 1'b0;
    endcase
  end

  // Software keeps the divided rate within the converter's range.
  assign conv_tick = src_tick && (div_cnt_ff == ((3'h1 << clock_divide_field) - 3'h1));

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      div_cnt_ff <= 3'h0;
    end
    else if (!busy)
    begin
      div_cnt_ff <= 3'h0;
    end
    else if (conv_tick)
    begin
      div_cnt_ff <= 3'h0;
    end
    else if (src_tick)
    begin
      div_cnt_ff <= div_cnt_ff + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Trigger selection; in deep stop only the counter overflow is accepted.
  always_comb
  begin
    case (trig_sel)
      adc_ctl_pkg::TRIG_RTC: hw_trig = rise[1];
      adc_ctl_pkg::TRIG_TMR0_CH0: hw_trig = rise[2] & ~deep_stop;
      adc_ctl_pkg::TRIG_TMR0_CH1: hw_trig = rise[3] & ~deep_stop;
      adc_ctl_pkg::TRIG_TMR1_CH0: hw_trig = rise[4] & ~deep_stop;
      default: hw_trig = 1'b0;
    endcase
  end

  // A disabled channel or an alternate clock in deep stop refuses every start.
  assign start_req = (sw_start_ff || (ctrl_ff[adc_ctl_pkg::CTRL_HWEN] && hw_trig))
    && (channel_select_field != adc_ctl_pkg::CH_DISABLED)
    && !(deep_stop && clk_sel == adc_ctl_pkg::CLK_ALT);

  ////////////////////////////////////////////////////////////////////////////////
  // Converter core.
  sar_engine #(
    .WIDTH(RES_WIDTH)
  ) u_sar (
    .mclk(mclk),
    .nrst(nrst),
    .conv_tick(conv_tick),
    .start(start_req),
    .long_sample(ctrl_ff[adc_ctl_pkg::CTRL_LONG]),
    .cmp_high(sync2_ff[5]),
    .dac_code_ff(dac_code_ff),
    .sample_on_ff(sample_on_ff),
    .busy_ff(busy),
    .done_ff(done_pulse),
    .result_ff(result)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Input routing decoded from the channel select field.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      ext_pin_sel_ff <= 3'h0;
      ext_pin_en_ff <= 1'b0;
      vss_sel_ff <= 1'b0;
      temp_sel_ff <= 1'b0;
      bandgap_sel_ff <= 1'b0;
      vrefh_sel_ff <= 1'b0;
      vrefl_sel_ff <= 1'b0;
      conv_enable_ff <= 1'b0;
    end
    else
    begin
      ext_pin_sel_ff <= channel_select_field[2:0];
      ext_pin_en_ff <= (channel_select_field <= adc_ctl_pkg::CH_EXT_LAST);
      vss_sel_ff <= (channel_select_field >= adc_ctl_pkg::CH_VSS_FIRST)
        && (channel_select_field <= adc_ctl_pkg::CH_VSS_LAST);
      temp_sel_ff <= (channel_select_field == adc_ctl_pkg::CH_TEMP);
      bandgap_sel_ff <= (channel_select_field == adc_ctl_pkg::CH_BANDGAP);
      vrefh_sel_ff <= (channel_select_field == adc_ctl_pkg::CH_VREFH);
      vrefl_sel_ff <= (channel_select_field == adc_ctl_pkg::CH_VREFL);
      conv_enable_ff <= (channel_select_field != adc_ctl_pkg::CH_DISABLED);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then the access completes.
  assign acc_wr = write && !waitrequest_ff;
  assign acc_rd = read && !waitrequest_ff;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      waitrequest_ff <= 1'b1;
    end
    else
    begin
      waitrequest_ff <= !((read || write) && waitrequest_ff);
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      readdata_ff <= 32'h0000_0000;
    end
    else if (read && waitrequest_ff)
    begin
      readdata_ff <= 32'h0000_0000;
      if (address == adc_ctl_pkg::REG_CTRL)
      begin
        readdata_ff[adc_ctl_pkg::CTRL_BITS-1:0] <= ctrl_ff;
      end
      else if (address == adc_ctl_pkg::REG_STAT)
      begin
        readdata_ff[adc_ctl_pkg::STAT_BUSY] <= busy;
        readdata_ff[adc_ctl_pkg::STAT_DONE] <= done_flag_ff;
        readdata_ff[adc_ctl_pkg::STAT_RES_HI:adc_ctl_pkg::STAT_RES_LO] <= result;
      end
    end
    else if (acc_rd)
    begin
      readdata_ff <= readdata_ff;
    end
  end

  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    if (byteenable[0])
    begin
      nxt_ctrl[7:0] = writedata[7:0];
    end
    if (byteenable[1])
    begin
      nxt_ctrl[12:8] = writedata[12:8];
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_ff <= adc_ctl_pkg::CTRL_RESET;
    end
    else if (acc_wr && address == adc_ctl_pkg::REG_CTRL)
    begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Writing one to the start bit asks for a single conversion.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      sw_start_ff <= 1'b0;
    end
    else
    begin
      sw_start_ff <= acc_wr && address == adc_ctl_pkg::REG_CTRL && byteenable[2]
        && writedata[adc_ctl_pkg::CTRL_START];
    end
  end

  // Done is sticky; a completion in the clearing cycle keeps it set.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      done_flag_ff <= 1'b0;
    end
    else if (done_pulse)
    begin
      done_flag_ff <= 1'b1;
    end
    else if (acc_wr && address == adc_ctl_pkg::REG_STAT && byteenable[0]
      && writedata[adc_ctl_pkg::STAT_DONE])
    begin
      done_flag_ff <= 1'b0;
    end
  end

endmodule

//--- pkg/adc_ctl_pkg.sv
// Purpose: Shared constants and types for the converter integration control block.
// Assumes: Avalon-MM byte addresses, 32-bit data, one aligned word per register.
// Notes: Channel codes, field positions and reset values live here only.
package adc_ctl_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses).
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;

  // Control register fields.
  localparam int CTRL_CH_LO = 0;
  localparam int CTRL_CH_HI = 4;
  localparam int CTRL_CLK_LO = 5;
  localparam int CTRL_CLK_HI = 6;
  localparam int CTRL_DIV_LO = 7;
  localparam int CTRL_DIV_HI = 8;
  localparam int CTRL_LONG = 9;
  localparam int CTRL_HWEN = 10;
  localparam int CTRL_TRIG_LO = 11;
  localparam int CTRL_TRIG_HI = 12;
  localparam int CTRL_START = 16;
  localparam int CTRL_BITS = 13;
  localparam logic [12:0] CTRL_RESET = 13'h001f;

  // Status register fields.
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_RES_LO = 16;
  localparam int STAT_RES_HI = 25;

  ////////////////////////////////////////////////////////////////////////////////
  // Channel select codes.
  localparam logic [4:0] CH_EXT_LAST = 5'h07;
  localparam logic [4:0] CH_VSS_FIRST = 5'h08;
  localparam logic [4:0] CH_VSS_LAST = 5'h12;
  localparam logic [4:0] CH_TEMP = 5'h16;
  localparam logic [4:0] CH_BANDGAP = 5'h17;
  localparam logic [4:0] CH_VREFH = 5'h1d;
  localparam logic [4:0] CH_VREFL = 5'h1e;
  localparam logic [4:0] CH_DISABLED = 5'h1f;

  ////////////////////////////////////////////////////////////////////////////////
  // Converter geometry and sample lengths minus one, in conversion clock ticks.
  localparam int RES_BITS = 10;
  localparam logic [4:0] SAMPLE_SHORT = 5'h03;
  localparam logic [4:0] SAMPLE_LONG = 5'h13;

  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_WAIT = 2'b01,
    PWR_DEEP_STOP = 2'b10
  } pwr_mode_t;

  typedef enum logic [1:0] {
    CLK_BUS = 2'b00,
    CLK_BUS_DIV2 = 2'b01,
    CLK_ALT = 2'b10,
    CLK_ASYNC = 2'b11
  } clk_src_t;

  typedef enum logic [1:0] {
    TRIG_RTC = 2'b00,
    TRIG_TMR0_CH0 = 2'b01,
    TRIG_TMR0_CH1 = 2'b10,
    TRIG_TMR1_CH0 = 2'b11
  } trig_src_t;

  typedef enum logic [1:0] {
    SAR_IDLE = 2'b00,
    SAR_SAMPLE = 2'b01,
    SAR_CONVERT = 2'b10
  } sar_state_t;

endpackage

//--- verilog/sar_engine.sv
// Purpose: Successive-approximation sequencer with a sample phase.
// Assumes: At most one trial per conversion tick; comparator input already synchronised.
// Notes: The start request is taken only while idle.
`timescale 1ns/1ps
module sar_engine #(
  parameter int WIDTH = adc_ctl_pkg::RES_BITS
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic conv_tick,
  input wire logic start,
  input wire logic long_sample,
  input wire logic cmp_high,
  output logic [WIDTH-1:0] dac_code_ff,
  output logic sample_on_ff,
  output logic busy_ff,
  output logic done_ff,
  output logic [WIDTH-1:0] result_ff
);

  adc_ctl_pkg::sar_state_t state_ff;
  logic [4:0] sample_cnt_ff;
  logic [WIDTH-1:0] trial_ff;
  // The comparator passes two flip-flops, so a decision waits until the new code has reached it.
  localparam logic [1:0] SETTLE = 2'h2;
  logic [1:0] settle_ff;
  logic pend_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer: sample, then at most one bit per tick from the top down.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_ff <= adc_ctl_pkg::SAR_IDLE;
      sample_cnt_ff <= 5'h00;
      trial_ff <= '0;
      settle_ff <= 2'h0;
      pend_ff <= 1'b0;
      dac_code_ff <= '0;
      sample_on_ff <= 1'b0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      result_ff <= '0;
    end
    else
    begin
      done_ff <= 1'b0;
      if (settle_ff != 2'h0)
      begin
        settle_ff <= settle_ff - 2'h1;
      end
      case (state_ff)
        adc_ctl_pkg::SAR_IDLE:
        begin
          if (start)
          begin
            state_ff <= adc_ctl_pkg::SAR_SAMPLE;
            sample_cnt_ff <= long_sample ? adc_ctl_pkg::SAMPLE_LONG : adc_ctl_pkg::SAMPLE_SHORT;
            sample_on_ff <= 1'b1;
            busy_ff <= 1'b1;
          end
        end
        adc_ctl_pkg::SAR_SAMPLE:
        begin
          if (conv_tick)
          begin
            if (sample_cnt_ff == 5'h00)
            begin
              state_ff <= adc_ctl_pkg::SAR_CONVERT;
              sample_on_ff <= 1'b0;
              settle_ff <= SETTLE;
              pend_ff <= 1'b0;
              trial_ff <= {1'b1, {(WIDTH-1){1'b0}}};
              dac_code_ff <= {1'b1, {(WIDTH-1){1'b0}}};
            end
            else
            begin
              sample_cnt_ff <= sample_cnt_ff - 5'h01;
            end
          end
        end
        adc_ctl_pkg::SAR_CONVERT:
        begin
          if (conv_tick)
          begin
            pend_ff <= 1'b1;
          end
          if ((conv_tick || pend_ff) && settle_ff == 2'h0)
          begin
            pend_ff <= 1'b0;
            settle_ff <= SETTLE;
            if (trial_ff[0])
            begin
              result_ff <= cmp_high ? dac_code_ff : (dac_code_ff & ~trial_ff);
              state_ff <= adc_ctl_pkg::SAR_IDLE;
              busy_ff <= 1'b0;
              done_ff <= 1'b1;
            end
            else
            begin
              dac_code_ff <= (cmp_high ? dac_code_ff : (dac_code_ff & ~trial_ff))
                | (trial_ff >> 1);
              trial_ff <= trial_ff >> 1;
            end
          end
        end
        default:
        begin
          state_ff <= adc_ctl_pkg::SAR_IDLE;
          busy_ff <= 1'b0;
          sample_on_ff <= 1'b0;
        end
      endcase
    end
  end

endmodule

//--- sim/analog_side_model.sv
// Purpose: Stands in for the analog inputs, the clock pins and the trigger sources.
// Assumes: The bench sets the input level and the trigger levels.
// Notes: The input sits half a step above lvl, so a conversion must return lvl.
`timescale 1ns/1ps
module analog_side_model (
  input wire logic [9:0] lvl,
  input wire logic [3:0] trig_lvl,
  input wire logic [9:0] dac_code_ff,
  output logic ext_osc_output,
  output logic local_async_conv_clock,
  output logic rtc_overflow,
  output logic tmr0_ch0_out,
  output logic tmr0_ch1_out,
  output logic tmr1_ch0_out,
  output logic cmp_high
);
  // Both oscillators run free and are unrelated to the bus clock.
  initial
  begin
    ext_osc_output = 1'b0;
    forever #70 ext_osc_output = ~ext_osc_output;
  end
  initial
  begin
    local_async_conv_clock = 1'b0;
    forever #90 local_async_conv_clock = ~local_async_conv_clock;
  end
  assign cmp_high = {lvl, 1'b1} > {dac_code_ff, 1'b0};
  assign {tmr1_ch0_out, tmr0_ch1_out, tmr0_ch0_out, rtc_overflow} = trig_lvl;
endmodule

//--- sim/adc_ctl_properties.sv
// Purpose: Port checks of input routing, enable and register bus timing.
// Assumes: One clock domain, nrst active low.
// Notes: Routing is judged against the channel field seen in CTRL read data.
`timescale 1ns/1ps
module adc_ctl_properties (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata_ff,
  input wire logic waitrequest_ff,
  input wire logic [2:0] ext_pin_sel_ff,
  input wire logic ext_pin_en_ff,
  input wire logic vss_sel_ff,
  input wire logic temp_sel_ff,
  input wire logic bandgap_sel_ff,
  input wire logic vrefh_sel_ff,
  input wire logic vrefl_sel_ff,
  input wire logic conv_enable_ff,
  input wire logic sample_on_ff
);
  wire logic [5:0] routes = {ext_pin_en_ff, vss_sel_ff, temp_sel_ff, bandgap_sel_ff,
    vrefh_sel_ff, vrefl_sel_ff};
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  sequence req_s;
    (read || write) && waitrequest_ff;
  endsequence
  sequence ctrl_rd_s;
    read && !waitrequest_ff && address == adc_ctl_pkg::REG_CTRL;
  endsequence
  sequence odd_rd_s;
    read && !waitrequest_ff && address != adc_ctl_pkg::REG_CTRL
      && address != adc_ctl_pkg::REG_STAT;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  wait_answer_a: assert property (req_s |=> !waitrequest_ff)
    else $error("no answer one cycle after request");
  wait_pulse_a: assert property (!waitrequest_ff |=> waitrequest_ff)
    else $error("waitrequest low for more than one cycle");
  wait_cause_a: assert property (!waitrequest_ff |-> $past(read || write))
    else $error("answer without request");
  unmapped_read_a: assert property (odd_rd_s |-> readdata_ff == 32'h0)
    else $error("unmapped read not zero");
  route_onehot_a: assert property ($onehot0(routes))
    else $error("more than one input routed");
  ext_route_a: assert property (ctrl_rd_s ##0 readdata_ff[4:3] == 2'h0 |->
    ext_pin_en_ff && ext_pin_sel_ff == readdata_ff[2:0])
    else $error("external pin not routed");
  ref_route_a: assert property (ctrl_rd_s |->
    vrefh_sel_ff == (readdata_ff[4:0] == adc_ctl_pkg::CH_VREFH)
    && vrefl_sel_ff == (readdata_ff[4:0] == adc_ctl_pkg::CH_VREFL))
    else $error("reference routing wrong");
  off_disable_a: assert property (ctrl_rd_s |->
    conv_enable_ff == (readdata_ff[4:0] != adc_ctl_pkg::CH_DISABLED))
    else $error("enable does not follow channel code");
  off_routes_a: assert property (!conv_enable_ff |-> routes == 6'h00)
    else $error("input routed while disabled");
  temp_route_a: assert property (ctrl_rd_s |->
    temp_sel_ff == (readdata_ff[4:0] == adc_ctl_pkg::CH_TEMP))
    else $error("temperature routing wrong");
  bandgap_route_a: assert property (ctrl_rd_s |->
    bandgap_sel_ff == (readdata_ff[4:0] == adc_ctl_pkg::CH_BANDGAP))
    else $error("bandgap routing wrong");
  sample_enable_a: assert property ($rose(sample_on_ff) |-> conv_enable_ff)
    else $error("sampling while disabled");
  sample_hold_a: assert property ($rose(sample_on_ff) |-> sample_on_ff [*4])
    else $error("sample phase too short");
endmodule

bind adc_chip_integration_control adc_ctl_properties u_props (.mclk, .nrst, .address, .read,
  .write, .readdata_ff, .waitrequest_ff, .ext_pin_sel_ff, .ext_pin_en_ff, .vss_sel_ff,
  .temp_sel_ff, .bandgap_sel_ff, .vrefh_sel_ff, .vrefl_sel_ff, .conv_enable_ff, .sample_on_ff);

//--- sim/tb.sv
// Purpose: Self-checking bench for the converter integration control block.
// Assumes: Avalon master with held requests; far side from analog_side_model.
// Notes: Each scenario is one task; conversions are polled through STATUS.
`timescale 1ns/1ps
module tb;
  logic mclk, nrst, read, write, waitrequest_ff, ext_osc_output, local_async_conv_clock;
  logic rtc_overflow, tmr0_ch0_out, tmr0_ch1_out, tmr1_ch0_out, cmp_high, sample_on_ff;
  logic ext_pin_en_ff, vss_sel_ff, temp_sel_ff, bandgap_sel_ff, vrefh_sel_ff, vrefl_sel_ff;
  logic conv_enable_ff;
  logic [3:0] address, byteenable, trig_lvl;
  logic [31:0] writedata, readdata_ff, rd;
  logic [1:0] power_mode;
  logic [2:0] ext_pin_sel_ff;
  logic [9:0] dac_code_ff, lvl;
  int error_cnt, samples_checked, cyc;

  adc_chip_integration_control u_dut (.mclk, .nrst, .address, .read, .write, .writedata,
    .byteenable, .readdata_ff, .waitrequest_ff, .power_mode, .ext_osc_output,
    .local_async_conv_clock, .rtc_overflow, .tmr0_ch0_out, .tmr0_ch1_out, .tmr1_ch0_out,
    .cmp_high, .ext_pin_sel_ff, .ext_pin_en_ff, .vss_sel_ff, .temp_sel_ff, .bandgap_sel_ff,
    .vrefh_sel_ff, .vrefl_sel_ff, .conv_enable_ff, .dac_code_ff, .sample_on_ff);
  analog_side_model u_analog (.lvl, .trig_lvl, .dac_code_ff, .ext_osc_output,
    .local_async_conv_clock, .rtc_overflow, .tmr0_ch0_out, .tmr0_ch1_out, .tmr1_ch0_out,
    .cmp_high);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Holds the request until waitrequest is sampled low at a rising edge.
  task automatic wait_ack();
    int n;
    n = 0;
    @(posedge mclk);
    while (waitrequest_ff !== 1'b0)
    begin
      @(posedge mclk);
      n++;
    end
    chk(n, 32'd1, "bus wait cycles");
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    wait_ack();
    write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic bus_rd(input logic [3:0] a);
    address <= a;
    read <= 1'b1;
    wait_ack();
    rd = readdata_ff;
    read <= 1'b0;
    @(posedge mclk);
  endtask
  function automatic logic [31:0] mk(input logic [4:0] ch, input logic [1:0] cs,
    input logic [1:0] dv, input logic lg, input logic hw, input logic [1:0] tg);
    return {19'h0, tg, hw, lg, dv, cs, ch};
  endfunction
  // Starts by software (src < 0) or by trigger line src, then polls for done.
  task automatic conv(input logic [31:0] ctl, input int src, input logic ok,
    input logic [9:0] v);
    int k;
    lvl <= v;
    bus_wr(adc_ctl_pkg::REG_STAT, 32'h2);
    bus_wr(adc_ctl_pkg::REG_CTRL, src < 0 ? ctl | 32'h1_0000 : ctl);
    if (src >= 0)
    begin
      trig_lvl[src] <= 1'b1;
      repeat (6) @(posedge mclk);
      trig_lvl[src] <= 1'b0;
    end
    k = 0;
    rd = 32'h0;
    while (rd[1] !== 1'b1 && k < 500)
    begin
      bus_rd(adc_ctl_pkg::REG_STAT);
      k++;
    end
    chk(rd[1], ok, "done");
    if (ok && !(ctl[4:0] inside {[5'h13:5'h15], [5'h18:5'h1c]}))
      chk(rd[25:16], v, "result");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    bus_rd(adc_ctl_pkg::REG_CTRL);
    chk(rd, {19'h0, adc_ctl_pkg::CTRL_RESET}, "ctrl reset");
    chk(conv_enable_ff, 1'b0, "enable at reset");
    bus_wr(4'h8, 32'h0);
    bus_rd(4'h8);
    chk(rd, 32'h0, "unmapped read");
    bus_rd(adc_ctl_pkg::REG_CTRL);
    chk(rd, 32'h1f, "unmapped write");
  endtask
  task automatic t_routes();
    logic [4:0] c;
    logic [9:0] got;
    logic [9:0] exp;
    for (int i = 0; i < 32; i++)
    begin
      c = i[4:0];
      bus_wr(adc_ctl_pkg::REG_CTRL, {27'h0, c});
      bus_rd(adc_ctl_pkg::REG_CTRL);
      got = {ext_pin_en_ff, ext_pin_en_ff ? ext_pin_sel_ff : 3'h0, vss_sel_ff, temp_sel_ff,
        bandgap_sel_ff, vrefh_sel_ff, vrefl_sel_ff, conv_enable_ff};
      exp = {c <= adc_ctl_pkg::CH_EXT_LAST, c <= adc_ctl_pkg::CH_EXT_LAST ? c[2:0] : 3'h0,
        c >= adc_ctl_pkg::CH_VSS_FIRST && c <= adc_ctl_pkg::CH_VSS_LAST,
        c == adc_ctl_pkg::CH_TEMP, c == adc_ctl_pkg::CH_BANDGAP, c == adc_ctl_pkg::CH_VREFH,
        c == adc_ctl_pkg::CH_VREFL, c != adc_ctl_pkg::CH_DISABLED};
      chk(got, exp, "routing");
    end
  endtask
  task automatic t_clocks();
    for (int s = 0; s < 4; s++)
      conv(mk(5'h03, s[1:0], s[1:0], 1'b0, 1'b0, 2'h0), -1, 1'b1,
        10'h2a5 ^ s[9:0]);
    conv(mk(5'h14, 2'h0, 2'h0, 1'b0, 1'b0, 2'h0), -1, 1'b1, 10'h0f0);
    chk({ext_pin_en_ff, vss_sel_ff, temp_sel_ff, bandgap_sel_ff, vrefh_sel_ff, vrefl_sel_ff,
      conv_enable_ff}, 32'h01, "reserved routes");
  endtask
  // Slow alternate clock with long sample, bandgap before temperature.
  task automatic t_temp();
    conv(mk(adc_ctl_pkg::CH_BANDGAP, 2'h2, 2'h3, 1'b1, 1'b0, 2'h0), -1, 1'b1, 10'h26c);
    conv(mk(adc_ctl_pkg::CH_TEMP, 2'h2, 2'h3, 1'b1, 1'b0, 2'h0), -1, 1'b1, 10'h1b3);
    chk(temp_sel_ff, 1'b1, "temp routed");
  endtask
  task automatic t_modes();
    power_mode <= adc_ctl_pkg::PWR_WAIT;
    conv(mk(5'h01, 2'h2, 2'h0, 1'b0, 1'b0, 2'h0), -1, 1'b1, 10'h3c3);
    power_mode <= adc_ctl_pkg::PWR_DEEP_STOP;
    conv(mk(5'h01, 2'h2, 2'h0, 1'b0, 1'b0, 2'h0), -1, 1'b0, 10'h111);
    conv(mk(5'h02, 2'h0, 2'h0, 1'b0, 1'b1, 2'h0), 0, 1'b1, 10'h0ab);
    conv(mk(5'h02, 2'h0, 2'h0, 1'b0, 1'b1, 2'h1), 1, 1'b0, 10'h0cd);
    power_mode <= adc_ctl_pkg::PWR_RUN;
  endtask
  task automatic t_trig();
    for (int m = 0; m < 2; m++)
    begin
      power_mode <= m[1:0];
      for (int t = 0; t < 4; t++)
        conv(mk(5'h05, 2'h0, 2'h0, 1'b0, 1'b1, t[1:0]), t, 1'b1,
          10'h155 + t[9:0]);
    end
    power_mode <= adc_ctl_pkg::PWR_RUN;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      error_cnt++;
      $display("[ERR] %0t run too long", $time);
      print_verdict();
    end
  end
  initial
  begin
    nrst = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    writedata = 32'h0;
    byteenable = 4'hf;
    power_mode = adc_ctl_pkg::PWR_RUN;
    lvl = 10'h0;
    trig_lvl = 4'h0;
    error_cnt = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    t_reset();
    t_routes();
    t_clocks();
    t_temp();
    t_modes();
    t_trig();
    print_verdict();
  end
endmodule
